// ---- inc/ccrb_pkg.sv ----
package ccrb_pkg;

   // ==========================================================
   // register map (byte offsets on the host bus)
   localparam logic [7:0] ADDR_CONTROL   = 8'h00;
   localparam logic [7:0] ADDR_STATUS    = 8'h02;
   localparam logic [7:0] ADDR_TARGET    = 8'h04;
   localparam logic [7:0] ADDR_TX        = 8'h06;
   localparam logic [7:0] ADDR_RX        = 8'h08;
   localparam logic [7:0] ADDR_TS_LOW    = 8'h0a;
   localparam logic [7:0] ADDR_TS_MID    = 8'h0c;
   localparam logic [7:0] ADDR_TS_HIGH   = 8'h0e;
   localparam logic [7:0] ADDR_SCRATCH   = 8'h10;
   localparam logic [7:0] ADDR_CHAN_SEL  = 8'h12;
   localparam logic [7:0] ADDR_CHAN_MASK = 8'h14;
   localparam logic [7:0] ADDR_CHAN_DLY  = 8'h16;
   localparam logic [7:0] ADDR_MUON_THR  = 8'h18;
   localparam logic [7:0] ADDR_MUON_WIN  = 8'h20;
   localparam logic [7:0] ADDR_DEAD_TIME = 8'h22;
   localparam logic [7:0] ADDR_REVISION  = 8'hfe;

   // ==========================================================
   // reset values and field layout
   localparam logic [15:0] CONTROL_RESET = 16'h3001;
   localparam logic [8:0]  THRESH_RESET  = 9'h014;
   localparam logic [3:0]  WINDOW_RESET  = 4'ha;
   localparam int CTRL_STAMP      = 15;
   localparam int CTRL_MUON_GATE  = 13;
   localparam int CTRL_GLITCH     = 12;
   localparam int CTRL_BUSY_BLOCK = 0;
   localparam int STAT_SPI_BUSY   = 0;
   localparam int STAT_DLY_BUSY   = 1;
   localparam int STAT_STUCK      = 2;
   localparam logic [15:0] TARGET_MASK = 16'h9fff;
   localparam int TARGET_WRITE    = 15;
   localparam logic [15:0] SEL_MASK    = 16'h01ff;
   localparam logic [7:0]  DEAD_MIN    = 8'h03;

   // ==========================================================
   // serial frame and timing
   localparam int FRAME_BITS  = 32;
   localparam int RX_BITS     = 16;
   localparam int FRAME_WRITE = 31;
   localparam int CLK_HZ      = 100_000_000;
   localparam int SPI_HZ      = 6_250_000;
   localparam int SPI_HALF    = CLK_HZ / (2 * SPI_HZ);

   typedef enum logic [1:0] {SPI_IDLE, SPI_SHIFT, SPI_TAIL} ccrb_spi_e;

   typedef struct packed {
      logic        cs;
      logic        rd;
      logic        we;
      logic [7:0]  addr;
      logic [15:0] data;
   } ccrb_bus_s;

   typedef struct packed {
      logic sclk;
      logic frame_select_n;
      logic mosi;
   } ccrb_spi_s;

   typedef struct packed {
      logic [8:0] muon_threshold;
      logic [3:0] muon_window;
      logic [7:0] dead_units;
      logic       glitch_filter_enable;
      logic       upstream_busy_block;
   } ccrb_cfg_s;

   typedef struct packed {
      logic       load;
      logic [4:0] slot;
      logic [3:0] channel;
      logic [7:0] value;
   } ccrb_dly_s;

   typedef struct packed {
      ccrb_bus_s         b1;
      ccrb_bus_s         b2;
      logic              we_prev;
      logic [3:0]        p1;
      logic [3:0]        p2;
      logic [15:0]       control;
      logic [15:0]       target;
      logic [15:0]       tx;
      logic [15:0]       rx;
      logic [47:0]       stamp;
      logic [15:0]       scratch;
      logic [8:0]        sel;
      logic [31:0][14:0] mask;
      logic [7:0]        dly;
      logic [8:0]        thr;
      logic [3:0]        win;
      logic [7:0]        dead;
      ccrb_spi_e         st;
      logic [7:0]        div;
      logic [5:0]        nbit;
      logic [31:0]       sh;
      logic [15:0]       rxsh;
      ccrb_spi_s         spi;
      logic              req;
      logic [2:0]        ack;
      logic [15:0]       rdata;
      logic              oe_n;
      logic              spare;
      ccrb_dly_s         dl;
   } ccrb_state_s;

   typedef struct packed {
      logic [47:0] cnt;
      logic [47:0] hold;
      logic [2:0]  req;
      logic        ack;
   } ccrb_ts_s;

endpackage

// ---- core/ccrb_bank.sv ----
`timescale 1ns/1ps
// How it works
// R1 - exactly 32 serial clocks per access
// R2 - frame select low only during access
// R3 - one 32-bit word shifted MSB first
// R4 - frame: write flag, address, data fields
// R5 - slave answers 16 bits on reads only
// R6 - target address write launches serial cycle
// R7 - software loads transmit data before write
// R8 - status shows serial, delay, stuck busy
// R9 - software polls serial busy before next
// R10 - target register: address, slot, cycle type
// R11 - read completion stores received word
// R12 - control bit 15 rise captures stamp
// R13 - control bit 13 gates muon flag
// R14 - control bit 12 enables glitch filter
// R15 - control bit 0 enables busy blocking
// R16 - scratch register stores host writes
// R17 - channel select: channel and slot fields
// R18 - per-slot channel masks, blocked at power-up
// R19 - channel delay value, 37 ps steps
// R20 - software waits delay busy per channel
// R21 - muon threshold, reset twenty
// R22 - muon window in 5 ns, reset ten
// R23 - dead time in 5 ns, minimum three
// R24 - master shifts on fall, samples late
module ccrb_bank #(
   parameter int          SPI_HALF = ccrb_pkg::SPI_HALF,
   parameter logic [15:0] REVISION = 16'h0001 // arbitrary value
) (
   input  wire logic               clk,             // system clock, 100 MHz
   input  wire logic               rst_n,           // async reset, active low
   input  wire logic               ts_clk,          // stamp counter clock
   input  wire logic               bus_cs_n,        // host chip select
   input  wire logic               bus_rd_n,        // host read strobe
   input  wire logic               bus_we_n,        // host write strobe
   input  wire logic [7:0]         bus_addr,        // host byte address
   input  wire logic [15:0]        bus_data_in,     // host data pins, in
   output logic      [15:0]        bus_data_out,    // host data pins, out
   output logic                    bus_data_oe_n,   // low while driving data
   output ccrb_pkg::ccrb_spi_s     spi_out,         // serial clock, select, data
   input  wire logic               miso,            // serial data from slave
   input  wire logic               delay_busy,      // delay setting pending
   input  wire logic               stuck_busy,      // trigger side stuck busy
   input  wire logic               muon_candidate_flag, // muon candidate in
   output logic                    spare_upstream_output, // gated muon flag
   output logic [31:0][14:0]       trigger_enable,  // channel masks per slot
   output ccrb_pkg::ccrb_dly_s     delay_out,       // delay load strobe
   output ccrb_pkg::ccrb_cfg_s     cfg              // trigger configuration
);

   // ==========================================================
   // state
   ccrb_pkg::ccrb_state_s s;
   ccrb_pkg::ccrb_state_s next_s;
   ccrb_pkg::ccrb_ts_s    t;
   ccrb_pkg::ccrb_ts_s    next_t;

   logic       wr_pulse;
   logic       rd_act;
   logic [4:0] sel_slot;
   logic [3:0] sel_chan;
   logic       miso_s;
   logic       dbusy_s;
   logic       stuck_s;
   logic       muon_s;
   logic [31:0] frame;

   assign sel_slot = s.sel[8:4];
   assign sel_chan = s.sel[3:0];
   assign miso_s   = s.p2[0];
   assign dbusy_s  = s.p2[1];
   assign stuck_s  = s.p2[2];
   assign muon_s   = s.p2[3];
   assign wr_pulse = s.b2.cs & s.b2.we & ~s.we_prev;
   assign rd_act   = s.b2.cs & s.b2.rd;

   // slot and register byte fill the low 13 bits of the 15-bit address field; built from the
   // word being written so the launch does not wait for the target flop
   assign frame = {s.b2.data[ccrb_pkg::TARGET_WRITE],     // R4
                   2'h0, s.b2.data[12:0], s.tx};          // R4

   // ==========================================================
   // main domain
   always_comb begin
      next_s = s;
      // pins arrive asynchronously; bus is held stable by the host
      next_s.b1.cs   = ~bus_cs_n;
      next_s.b1.rd   = ~bus_rd_n;
      next_s.b1.we   = ~bus_we_n;
      next_s.b1.addr = bus_addr;
      next_s.b1.data = bus_data_in;
      next_s.b2      = s.b1;
      next_s.we_prev = s.b2.cs & s.b2.we;
      next_s.p1      = {muon_candidate_flag, stuck_busy, delay_busy, miso};
      next_s.p2      = s.p1;
      next_s.dl.load = 1'b0;

      // ------- register writes
      if (wr_pulse) begin
         case (s.b2.addr)
            ccrb_pkg::ADDR_CONTROL: begin
               next_s.control = s.b2.data;
               if (s.b2.data[ccrb_pkg::CTRL_STAMP] &&
                   !s.control[ccrb_pkg::CTRL_STAMP]) begin
                  next_s.req = ~s.req; // R12
               end
            end
            ccrb_pkg::ADDR_TARGET: begin
               next_s.target = s.b2.data & ccrb_pkg::TARGET_MASK; // R10
            end
            ccrb_pkg::ADDR_TX:       next_s.tx = s.b2.data;
            ccrb_pkg::ADDR_SCRATCH:  next_s.scratch = s.b2.data; // R16
            ccrb_pkg::ADDR_CHAN_SEL: next_s.sel = s.b2.data[8:0]; // R17
            ccrb_pkg::ADDR_CHAN_MASK: begin
               next_s.mask[sel_slot] = s.b2.data[15:1]; // R18
            end
            ccrb_pkg::ADDR_CHAN_DLY: begin
               next_s.dly        = s.b2.data[7:0]; // R19
               next_s.dl.load    = 1'b1;
               next_s.dl.slot    = sel_slot;
               next_s.dl.channel = sel_chan;
               next_s.dl.value   = s.b2.data[7:0];
            end
            ccrb_pkg::ADDR_MUON_THR:  next_s.thr = s.b2.data[8:0]; // R21
            ccrb_pkg::ADDR_MUON_WIN:  next_s.win = s.b2.data[3:0]; // R22
            ccrb_pkg::ADDR_DEAD_TIME: next_s.dead = s.b2.data[7:0]; // R23
            default: ;
         endcase
      end

      // ------- serial master
      case (s.st)
         ccrb_pkg::SPI_IDLE: begin
            // a launch during a running cycle is dropped; software polls first
            if (wr_pulse && s.b2.addr == ccrb_pkg::ADDR_TARGET) begin // R6
               next_s.st = ccrb_pkg::SPI_SHIFT;
               next_s.spi.frame_select_n = 1'b0; // R2
               next_s.spi.sclk = 1'b0;
               next_s.div  = 8'h00;
               next_s.nbit = 6'h00;
               next_s.sh   = frame; // R4
               next_s.spi.mosi = frame[ccrb_pkg::FRAME_WRITE]; // R3
            end
         end
         ccrb_pkg::SPI_SHIFT: begin
            next_s.div = s.div + 8'h01;
            if (s.div == 8'(SPI_HALF - 1)) begin
               next_s.div = 8'h00;
               if (!s.spi.sclk) begin
                  next_s.spi.sclk = 1'b1; // R1
               end else begin
                  // sample the synchronised line just before the falling
                  // edge, a full period after the slave changed it
                  next_s.spi.sclk = 1'b0; // R24
                  if (s.nbit >= 6'(ccrb_pkg::FRAME_BITS - ccrb_pkg::RX_BITS)) begin
                     next_s.rxsh = {s.rxsh[14:0], miso_s};
                  end
                  if (s.nbit == 6'(ccrb_pkg::FRAME_BITS - 1)) begin // R1
                     next_s.st = ccrb_pkg::SPI_TAIL;
                  end else begin
                     next_s.nbit     = s.nbit + 6'h01;
                     // rotate, not shift: the write flag must survive the frame
                     next_s.sh       = {s.sh[30:0], s.sh[31]};
                     next_s.spi.mosi = s.sh[30]; // R3
                  end
               end
            end
         end
         ccrb_pkg::SPI_TAIL: begin
            next_s.div = s.div + 8'h01;
            if (s.div == 8'(SPI_HALF - 1)) begin
               next_s.div = 8'h00;
               next_s.st  = ccrb_pkg::SPI_IDLE;
               next_s.spi.frame_select_n = 1'b1; // R2
               next_s.spi.mosi = 1'b0;
               // 31 moves leave the write flag one place below the top; the
               // target register may already hold the next request
               if (!s.sh[ccrb_pkg::FRAME_WRITE - 1]) begin
                  next_s.rx = s.rxsh; // R11
               end
            end
         end
         default: begin
            next_s.st = ccrb_pkg::SPI_IDLE;
            next_s.spi.frame_select_n = 1'b1;
         end
      endcase

      // ------- stamp answer: hold is stable once the ack toggle is seen
      next_s.ack = {s.ack[1:0], t.ack};
      if (s.ack[2] != s.ack[1]) begin
         next_s.stamp = t.hold; // R12
      end

      // ------- outputs from flops
      next_s.spare = muon_s & s.control[ccrb_pkg::CTRL_MUON_GATE]; // R13
      next_s.oe_n  = ~rd_act;
      case (s.b2.addr)
         ccrb_pkg::ADDR_CONTROL:   next_s.rdata = s.control;
         ccrb_pkg::ADDR_STATUS:    next_s.rdata = {13'h0000, stuck_s, dbusy_s,
                                                   s.st != ccrb_pkg::SPI_IDLE}; // R8
         ccrb_pkg::ADDR_TARGET:    next_s.rdata = s.target;
         ccrb_pkg::ADDR_TX:        next_s.rdata = s.tx;
         ccrb_pkg::ADDR_RX:        next_s.rdata = s.rx;
         ccrb_pkg::ADDR_TS_LOW:    next_s.rdata = s.stamp[15:0];
         ccrb_pkg::ADDR_TS_MID:    next_s.rdata = s.stamp[31:16];
         ccrb_pkg::ADDR_TS_HIGH:   next_s.rdata = s.stamp[47:32];
         ccrb_pkg::ADDR_SCRATCH:   next_s.rdata = s.scratch;
         ccrb_pkg::ADDR_CHAN_SEL:  next_s.rdata = {7'h00, s.sel};
         ccrb_pkg::ADDR_CHAN_MASK: next_s.rdata = {s.mask[sel_slot], 1'b0};
         ccrb_pkg::ADDR_CHAN_DLY:  next_s.rdata = {8'h00, s.dly};
         ccrb_pkg::ADDR_MUON_THR:  next_s.rdata = {7'h00, s.thr};
         ccrb_pkg::ADDR_MUON_WIN:  next_s.rdata = {12'h000, s.win};
         ccrb_pkg::ADDR_DEAD_TIME: next_s.rdata = {8'h00, s.dead};
         ccrb_pkg::ADDR_REVISION:  next_s.rdata = REVISION;
         default:                  next_s.rdata = 16'h0000;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s         <= '0;
         s.control <= ccrb_pkg::CONTROL_RESET; // R13 R14 R15
         s.thr     <= ccrb_pkg::THRESH_RESET;  // R21
         s.win     <= ccrb_pkg::WINDOW_RESET;  // R22
         s.st      <= ccrb_pkg::SPI_IDLE;
         s.spi.frame_select_n <= 1'b1;         // R2
         s.oe_n    <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   // ==========================================================
   // stamp domain: free counter, capture on request toggle
   always_comb begin
      next_t     = t;
      next_t.cnt = t.cnt + 48'h000000000001;
      next_t.req = {t.req[1:0], s.req};
      if (t.req[2] != t.req[1]) begin
         next_t.hold = t.cnt; // R12
         next_t.ack  = ~t.ack;
      end
   end

   always_ff @(posedge ts_clk or negedge rst_n) begin
      if (!rst_n) begin
         t <= '0;
      end else begin
         t <= next_t;
      end
   end

   // ==========================================================
   // outputs
   assign bus_data_out          = s.rdata;
   assign bus_data_oe_n         = s.oe_n;
   assign spi_out               = s.spi;
   assign spare_upstream_output = s.spare;
   assign trigger_enable        = s.mask; // R18
   assign delay_out             = s.dl;

   always_comb begin
      cfg.muon_threshold       = s.thr;
      cfg.muon_window          = s.win;
      // zero still gives the minimum dead time of three 5 ns units
      cfg.dead_units           = (s.dead < ccrb_pkg::DEAD_MIN) ?
                                 ccrb_pkg::DEAD_MIN : s.dead; // R23
      cfg.glitch_filter_enable = s.control[ccrb_pkg::CTRL_GLITCH]; // R14
      cfg.upstream_busy_block  = s.control[ccrb_pkg::CTRL_BUSY_BLOCK]; // R15
   end

endmodule

// ---- test/ccrb_slave_model.sv ----
`timescale 1ns/1ps
module ccrb_slave_model (
   input  wire ccrb_pkg::ccrb_spi_s spi_in, // lines from the master
   output logic                     miso,   // reply, driven on reads only
   output logic [31:0]              frame   // last complete frame seen
);
   logic [15:0] mem [256];
   logic [31:0] sh;
   logic [15:0] q;
   logic        rd;
   int          n;
   // ==========================================================
   // one remote board; slot field ignored
   initial begin
      miso = 1'b0;
      frame = '0;
      n = 0;
      rd = 1'b0;
      for (int i = 0; i < 256; i++) mem[i] = 16'hc300 | 16'(i);
   end
   always @(negedge spi_in.frame_select_n) n = 0;
   // sample on the edge opposite to the master's shifting edge
   always @(posedge spi_in.sclk) begin
      sh = {sh[30:0], spi_in.mosi};
      n = n + 1;
   end
   always @(negedge spi_in.sclk) begin
      if (n == 16) begin
         rd = !sh[15];
         q = mem[sh[7:0]];
      end
      if (rd && n >= 16 && n < 32) begin
         miso = q[15];
         q = q << 1;
      end else if (rd && n == 32) begin
         miso = ~miso; // no pull on the line, so a released level is not held
      end
      if (n == 32) begin
         frame = sh;
         if (sh[31]) mem[sh[23:16]] = sh[15:0];
         rd = 1'b0;
      end
   end
endmodule

// ---- test/ccrb_assertions.sv ----
`timescale 1ns/1ps
module ccrb_assertions #(
   parameter int SPI_HALF = 8
) (
   input wire logic                clk,       // system clock
   input wire logic                rst_n,     // async reset, active low
   input wire ccrb_pkg::ccrb_spi_s spi_out,   // serial lines
   input wire ccrb_pkg::ccrb_dly_s delay_out, // delay load strobe
   input wire ccrb_pkg::ccrb_cfg_s cfg        // trigger configuration
);
   localparam int FLO = 65 * SPI_HALF - 1;
   localparam int FHI = 65 * SPI_HALF + 1;
   logic [5:0] rises;
   logic       sclk_q;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // ==========================================================
   // rising serial clocks seen in the current frame
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rises <= '0;
         sclk_q <= 1'b0;
      end else begin
         sclk_q <= spi_out.sclk;
         if (spi_out.frame_select_n) rises <= '0;
         else if (spi_out.sclk && !sclk_q) rises <= rises + 6'h01;
      end
   end
   // ==========================================================
   // serial link
   property p_count;
      $rose(spi_out.frame_select_n) |-> rises == 6'd32;
   endproperty
   a_count: assert property (p_count) else $error("serial clock count wrong");
   property p_half;
      $rose(spi_out.sclk) |-> ##SPI_HALF $fell(spi_out.sclk);
   endproperty
   a_half: assert property (p_half) else $error("serial clock high half wrong");
   property p_first;
      $fell(spi_out.frame_select_n) |-> !spi_out.sclk ##SPI_HALF $rose(spi_out.sclk);
   endproperty
   a_first: assert property (p_first) else $error("first serial clock late");
   property p_len;
      $fell(spi_out.frame_select_n) |-> ##[FLO:FHI] $rose(spi_out.frame_select_n);
   endproperty
   a_len: assert property (p_len) else $error("frame length wrong");
   property p_idle;
      spi_out.frame_select_n |-> !spi_out.sclk;
   endproperty
   a_idle: assert property (p_idle) else $error("serial clock outside frame");
   property p_mosi;
      spi_out.sclk |-> $stable(spi_out.mosi);
   endproperty
   a_mosi: assert property (p_mosi) else $error("data moved while clock high");
   // ==========================================================
   // trigger configuration
   property p_load;
      delay_out.load |=> !delay_out.load;
   endproperty
   a_load: assert property (p_load) else $error("delay load longer than a cycle");
   property p_dead;
      cfg.dead_units >= 8'h03;
   endproperty
   a_dead: assert property (p_dead) else $error("dead time below minimum");
endmodule

bind ccrb_bank ccrb_assertions #(.SPI_HALF(SPI_HALF)) u_chk (
   .clk(clk), .rst_n(rst_n), .spi_out(spi_out), .delay_out(delay_out), .cfg(cfg));

// ---- test/tb.sv ----
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin failures++; \
   $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module tb;
   logic clk, rst_n, ts_clk, cs_n, rd_n, we_n, miso, dbusy, sbusy, mflag, oe_n, spare;
   logic [7:0]  addr;
   logic [15:0] din, dout, v;
   logic [31:0] frame;
   logic [47:0] stamp, t0;
   logic [31:0][14:0]   ten;
   ccrb_pkg::ccrb_spi_s spi;
   ccrb_pkg::ccrb_dly_s dly, last_dly;
   ccrb_pkg::ccrb_cfg_s cfg;
   int failures = 0, samples_checked = 0, nfr = 0, tsn = 0, n0;
   // ==========================================================
   // register rows: offset, reset value, value read after writing all ones
   logic [7:0] ra [15] = '{8'h02, 8'h06, 8'h08, 8'h0a, 8'h0c, 8'h0e, 8'h10, 8'h12,
      8'h14, 8'h16, 8'h18, 8'h20, 8'h22, 8'hfe, 8'h00};
   logic [15:0] rv [15] = '{16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0,
      16'h0, 16'h0, 16'h0014, 16'h000a, 16'h0, 16'h0042, 16'h3001};
   logic [15:0] wb [15] = '{16'h0, 16'hffff, 16'h0, 16'h0, 16'h0, 16'h0, 16'hffff, 16'h01ff,
      16'hfffe, 16'h00ff, 16'h01ff, 16'h000f, 16'h00ff, 16'h0042, 16'hffff};
   logic [15:0] cv [2] = '{16'h0000, 16'h3001};
   // revision value is arbitrary; short serial half period keeps the run brief
   ccrb_bank #(.SPI_HALF(2), .REVISION(16'h0042)) DUT (.clk(clk), .rst_n(rst_n),
      .ts_clk(ts_clk), .bus_cs_n(cs_n), .bus_rd_n(rd_n), .bus_we_n(we_n), .bus_addr(addr),
      .bus_data_in(din), .bus_data_out(dout), .bus_data_oe_n(oe_n), .spi_out(spi),
      .miso(miso), .delay_busy(dbusy), .stuck_busy(sbusy), .muon_candidate_flag(mflag),
      .spare_upstream_output(spare), .trigger_enable(ten), .delay_out(dly), .cfg(cfg));
   ccrb_slave_model slave (.spi_in(spi), .miso(miso), .frame(frame));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial begin
      ts_clk = 1'b0;
      #3;
      forever #40 ts_clk = ~ts_clk;
   end
   always @(posedge ts_clk) if (rst_n) tsn++;
   always @(negedge spi.frame_select_n) nfr++;
   always @(posedge clk) if (dly.load === 1'b1) last_dly <= dly;
   // ==========================================================
   // host bus; strobes are synced inside, so a write holds them four cycles and a read seven
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk);
      cs_n <= 1'b0; we_n <= 1'b0; addr <= a; din <= d;
      repeat (4) @(posedge clk);
      cs_n <= 1'b1; we_n <= 1'b1;
      repeat (4) @(posedge clk);
   endtask
   task automatic rd(input logic [7:0] a, output logic [15:0] d);
      @(posedge clk);
      cs_n <= 1'b0; rd_n <= 1'b0; addr <= a;
      repeat (6) @(posedge clk);
      #1 d = dout;
      `CHK(oe_n, 1'b0)
      @(posedge clk);
      cs_n <= 1'b1; rd_n <= 1'b1;
      repeat (5) @(posedge clk);
      `CHK(oe_n, 1'b1)
   endtask
   task automatic idle;
      logic [15:0] s;
      int k;
      k = 0;
      rd(8'h02, s);
      while (s[0] !== 1'b0 && k < 60) begin
         rd(8'h02, s);
         k++;
      end
      `CHK(s[0], 1'b0)
   endtask
   task automatic summarize;
      if (failures == 0 && samples_checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      #300us;
      failures++;
      summarize();
   end
   // ==========================================================
   // main sequence
   initial begin
      rst_n = 1'b0; cs_n = 1'b1; rd_n = 1'b1; we_n = 1'b1; addr = '0; din = '0;
      dbusy = 1'b0; sbusy = 1'b0; mflag = 1'b1;
      repeat (4) @(posedge clk);
      #1 `CHK({cfg.muon_threshold, cfg.muon_window, cfg.dead_units}, 21'h014a03)
      `CHK({cfg.glitch_filter_enable, cfg.upstream_busy_block}, 2'b11)
      `CHK(ten, 480'h0)
      @(posedge clk);
      rst_n <= 1'b1;
      for (int i = 0; i < 15; i++) begin
         rd(ra[i], v);
         `CHK(v, rv[i])
      end
      for (int i = 0; i < 15; i++) begin
         wr(ra[i], 16'hffff);
         rd(ra[i], v);
         `CHK(v, wb[i])
      end
      `CHK(ten[31], 15'h7fff)
      for (int i = 0; i < 2; i++) begin
         wr(8'h00, cv[i]);
         repeat (6) @(posedge clk);
         #1 `CHK({spare, cfg.glitch_filter_enable, cfg.upstream_busy_block}, {cv[i][13], cv[i][12], cv[i][0]})
      end
      wr(8'h12, 16'h0023);
      wr(8'h14, 16'h000a);
      `CHK(ten[2], 15'h0005)
      rd(8'h02, v);
      `CHK(v[1], 1'b0)
      wr(8'h16, 16'h0040);
      `CHK(last_dly, {1'b1, 5'd2, 4'd3, 8'h40})
      wr(8'h22, 16'h0002);
      `CHK(cfg.dead_units, 8'h03)
      @(posedge clk);
      dbusy <= 1'b1; sbusy <= 1'b1;
      rd(8'h02, v);
      `CHK(v, 16'h0006)
      dbusy <= 1'b0; sbusy <= 1'b0;
      wr(8'h06, 16'h4321);
      wr(8'h04, 16'h8255);
      rd(8'h02, v);
      `CHK(v, 16'h0001)
      idle();
      `CHK(frame, 32'h82554321)
      wr(8'h04, 16'h0255);
      idle();
      rd(8'h08, v);
      `CHK(v, 16'h4321)
      n0 = nfr;
      wr(8'h04, 16'h0077);
      wr(8'h04, 16'h8266);
      idle();
      `CHK(nfr - n0, 1)
      rd(8'h08, v);
      `CHK(v, 16'hc377)
      rd(8'h04, v);
      `CHK(v, 16'h8266)
      wr(8'h00, 16'h0000);
      wr(8'h00, 16'h8000);
      t0 = 48'(tsn);
      repeat (90) @(posedge clk);
      rd(8'h0a, stamp[15:0]);
      rd(8'h0c, stamp[31:16]);
      rd(8'h0e, stamp[47:32]);
      `CHK((stamp + 48'd8 - t0) <= 48'd16, 1'b1)
      wr(8'h00, 16'h8000);
      repeat (90) @(posedge clk);
      rd(8'h0a, v);
      `CHK(v, stamp[15:0])
      summarize();
   end
endmodule
